// *** bench/tb_top.sv ***
// Self-checking bench for the shadow data port
`timescale 1ns/100ps
`include "usd_params.svh"
module tb_top;
   localparam int CPB = 8;
   localparam int FD = 4;
   localparam logic [31:0] EMPTY = 32'h00000060;
   localparam logic [31:0] ALIAS = `USD_ADDR_SHADOW_1;
   localparam logic [31:0] LINE_STATUS_REGISTER = `USD_ADDR_LINE_STATUS;
   logic clk, rstn, rd, wr, irq, utx, irtxn, waitreq, peer_rx, peer_ir;
   logic [31:0] addr, wdata, rdata, d;
   logic [3:0] be;
   int miscompares = 0;
   int check_count = 0;
   usd_shadow_port #(.FIFO_DEPTH(FD), .CLKS_PER_BIT(CPB)) dut (.i_clk(clk), .i_rstn(rstn),
      .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
      .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
      .i_uart_rx(peer_rx), .i_ir_rx(peer_ir), .o_uart_tx(utx), .o_ir_tx_n(irtxn), .o_irq(irq));
   usd_peer #(.CPB(CPB)) peer (.i_clk(clk), .i_line(utx & irtxn), .o_rx(peer_rx), .o_ir(peer_ir));
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Holds the request until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      input logic [3:0] b);
      @(posedge clk);
      addr <= a;
      wdata <= wd;
      be <= b;
      rd <= ~w;
      wr <= w;
      // Only the watchdog ends a wait that never sees an answer
      do begin
         @(posedge clk);
      end while (waitreq !== 1'b0);
      d = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic wrt(input logic [31:0] a, input logic [31:0] wd);
      bus(1'b1, a, wd, 4'hF);
   endtask
   task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, 4'hF);
      chk(d, exp);
   endtask
   task automatic wait_got(input int n);
      for (int k = 0; k < 3000 && peer.got_q.size() < n; k++) @(posedge clk);
      chk(peer.got_q.size(), n);
   endtask
   task automatic t_reset();
      chk({28'h0, waitreq, utx, irtxn, irq}, 32'hE);
      rdc(LINE_STATUS_REGISTER, EMPTY);
      rdc(ALIAS, 32'h0);
      bus(1'b1, `USD_ADDR_MODE_CTRL, 32'h1, 4'hE);
      rdc(`USD_ADDR_MODE_CTRL, 32'h0);
      rdc(32'h50001000, 32'h0);
   endtask
   task automatic t_rx_off();
      for (int i = 0; i < 16; i += 5) begin
         peer.send(8'h5A ^ i[7:0], 1'b0);
         repeat (4) @(posedge clk);
         chk({31'h0, irq}, 32'h0);
         rdc(LINE_STATUS_REGISTER, EMPTY | 32'h1);
         rdc(`USD_ADDR_SHADOW_BASE + 4 * i, {24'h0, 8'h5A ^ i[7:0]});
      end
      peer.send(8'h11, 1'b0);
      peer.send(8'h22, 1'b0);
      repeat (4) @(posedge clk);
      rdc(LINE_STATUS_REGISTER, EMPTY | 32'h3);
      rdc(ALIAS, 32'h22);
      rdc(LINE_STATUS_REGISTER, EMPTY);
   endtask
   task automatic t_rx_fifo();
      wrt(`USD_ADDR_FIFO_CTRL, 32'h1);
      wrt(`USD_ADDR_INT_MASK, 32'h1);
      for (int i = 0; i <= FD; i++) peer.send(8'hC0 + i[7:0], 1'b0);
      repeat (4) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      rdc(LINE_STATUS_REGISTER, EMPTY | 32'h3);
      bus(1'b0, `USD_ADDR_INT_STATUS, 32'h0, 4'hF);
      chk(d & 32'h3, 32'h3);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      for (int i = 0; i < FD; i++) rdc(ALIAS + 4 * i, 32'hC0 + i);
      rdc(LINE_STATUS_REGISTER, EMPTY);
      wrt(`USD_ADDR_INT_MASK, 32'h0);
   endtask
   task automatic t_tx_off();
      wrt(`USD_ADDR_FIFO_CTRL, 32'h0);
      peer.got_q.delete();
      rdc(LINE_STATUS_REGISTER, EMPTY);
      wrt(ALIAS, 32'h1A5);
      wrt(ALIAS, 32'h3C);
      rdc(LINE_STATUS_REGISTER, 32'h0);
      wrt(ALIAS, 32'h96);
      wait_got(2);
      chk(peer.got_q[0], 8'hA5);
      chk(peer.got_q[1], 8'h96);
      // Holding-empty rise is the only event since the last status read
      rdc(`USD_ADDR_INT_STATUS, 32'h4);
   endtask
   task automatic t_tx_fifo();
      wrt(`USD_ADDR_FIFO_CTRL, 32'h1);
      repeat (2 * CPB) @(posedge clk);
      peer.got_q.delete();
      for (int i = 0; i < FD + 2; i++) wrt(ALIAS, 32'h40 + i);
      wait_got(FD + 1);
      for (int i = 0; i <= FD; i++) chk(peer.got_q[i], 32'h40 + i);
      repeat (12 * CPB) @(posedge clk);
      chk(peer.got_q.size(), FD + 1);
   endtask
   task automatic t_ir();
      wrt(`USD_ADDR_MODE_CTRL, 32'h1);
      peer.got_q.delete();
      peer.send(8'h3C, 1'b1);
      repeat (4) @(posedge clk);
      rdc(ALIAS, 32'h3C);
      wrt(ALIAS, 32'h81);
      wait_got(1);
      chk(peer.got_q[0], 8'h81);
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Run is about 1900 cycles; the limit leaves ample room
   initial begin
      #160000;
      miscompares++;
      report_and_stop();
   end
   initial begin
      rstn = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      addr = 32'h0;
      wdata = 32'h0;
      be = 4'hF;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_rx_off();
      t_rx_fifo();
      t_tx_off();
      t_tx_fifo();
      t_ir();
      report_and_stop();
   end
endmodule // tb_top

// *** bench/usd_peer.sv ***
// Serial peer that sends frames to the port and collects what it sends
`timescale 1ns/100ps
module usd_peer #(
   parameter int CPB = 8
) (
   input wire logic i_clk,
   input wire logic i_line,
   output logic o_rx,
   output logic o_ir
);
   logic [7:0] got_q[$];
   logic [7:0] sh;
   // Idle levels: serial high, infrared low
   initial begin
      o_rx = 1'b1;
      o_ir = 1'b0;
   end
   task automatic send(input logic [7:0] b, input logic ir);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge i_clk);
         if (ir) o_ir <= ~f[i];
         else o_rx <= f[i];
         repeat (CPB - 1) @(posedge i_clk);
      end
   endtask
   always begin
      @(negedge i_line);
      repeat (CPB / 2) @(posedge i_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (CPB) @(posedge i_clk);
         sh[i] = i_line;
      end
      repeat (CPB) @(posedge i_clk);
      got_q.push_back(sh);
   end
endmodule // usd_peer

// *** logic/usd_fifo.sv ***
// Character queue with a single-entry overwrite mode
`timescale 1ns/100ps
module usd_fifo #(
   parameter int DW = 8,
   parameter int DEPTH = 16
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   usd_fifo_if.fifo f
);
   localparam int CW = $clog2(DEPTH + 1);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

   logic [DW-1:0] mem [DEPTH];
   logic [PW-1:0] rd_reg;
   logic [PW-1:0] wr_reg;
   logic [CW-1:0] count_reg;
   logic do_pop;
   logic do_push;
   logic do_over;

   assign f.empty = (count_reg == '0);
   assign f.full = f.single ? !f.empty : (count_reg == CNT_FULL);
   assign f.head = mem[rd_reg];
   assign f.count = count_reg;
   assign do_pop = f.pop && !f.empty;
   assign do_push = f.push && (!f.full || do_pop);
   assign do_over = f.push && f.full && f.single && !do_pop;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rd_reg <= '0;
         wr_reg <= '0;
         count_reg <= '0;
      end else if (f.flush) begin
         rd_reg <= '0;
         wr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (do_push) begin
            wr_reg <= (wr_reg == PTR_LAST) ? '0 : wr_reg + PW'(1);
         end
         if (do_pop) begin
            rd_reg <= (rd_reg == PTR_LAST) ? '0 : rd_reg + PW'(1);
         end
         count_reg <= count_reg + CW'(do_push) - CW'(do_pop);
      end
   end

   // Storage has no reset; the count alone says what is valid
   always_ff @(posedge i_clk) begin
      if (do_push && !f.flush) begin
         mem[wr_reg] <= f.push_data;
      end else if (do_over && !f.flush) begin
         mem[rd_reg] <= f.push_data;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   property p_fill;
      f.push && !f.full && !f.pop && !f.flush |=> count_reg == $past(count_reg) + CW'(1);
   endproperty
   property p_drop;
      f.push && f.full && !f.single && !f.pop && !f.flush |=> $stable(count_reg) && $stable(f.head);
   endproperty
   property p_over;
      do_over && !f.flush |=> f.head == $past(f.push_data) && count_reg == CW'(1);
   endproperty

   AST_FIFO_BOUND: assert property (count_reg <= CNT_FULL) else $error("queue overfilled");
   AST_FIFO_FILL: assert property (p_fill) else $error("accepted write not counted");
   AST_FIFO_DROP: assert property (p_drop) else $error("write to full queue kept");
   AST_FIFO_OVER: assert property (p_over) else $error("pending byte not replaced");
endmodule // usd_fifo

// *** logic/usd_fifo_if.sv ***
// Interface between a character queue and its user
`timescale 1ns/100ps
interface usd_fifo_if #(parameter int DW = 8, parameter int DEPTH = 16);
   localparam int CW = $clog2(DEPTH + 1);
   logic push;
   logic [DW-1:0] push_data;
   logic pop;
   logic single;
   logic flush;
   logic [DW-1:0] head;
   logic empty;
   logic full;
   logic [CW-1:0] count;
   modport fifo(input push, push_data, pop, single, flush, output head, empty, full, count);
   modport user(output push, push_data, pop, single, flush, input head, empty, full, count);
endinterface

// *** logic/usd_params.svh ***
// Constants for the shadow receive/transmit data port block
`ifndef USD_PARAMS_SVH
`define USD_PARAMS_SVH

`define USD_WORD_BYTES 32'h00000004
`define USD_ADDR_SHADOW_1 32'h50001034
`define USD_ADDR_SHADOW_2 32'h50001038
`define USD_ADDR_SHADOW_BASE (`USD_ADDR_SHADOW_1 - `USD_WORD_BYTES)
`define USD_SHADOW_SPAN 32'h00000040
`define USD_ADDR_FIFO_CTRL 32'h50001008
`define USD_ADDR_MODE_CTRL 32'h5000100C
`define USD_ADDR_LINE_STATUS 32'h50001014
`define USD_ADDR_INT_STATUS 32'h50001080
`define USD_ADDR_INT_MASK 32'h50001084

`define USD_FCR_EN 0
`define USD_MODE_IR 0
`define USD_LSR_DR 0
`define USD_LSR_OE 1
`define USD_LSR_TX_HOLDING_EMPTY_FLAG 5
`define USD_LSR_TEMT 6
`define USD_INT_RX 0
`define USD_INT_OE 1
`define USD_INT_TX_HOLDING_EMPTY_FLAG 2
`define USD_INT_W 3

`define USD_DATA_W 8
`define USD_FIFO_DEPTH 16
`define USD_CLK_HZ 125000000
`define USD_BAUD 115200

`endif

// *** logic/usd_pkg.sv ***
// Types shared by the shadow data port modules
package usd_pkg;
   typedef enum logic [1:0] {
      USD_TX_IDLE = 2'h0,
      USD_TX_START = 2'h1,
      USD_TX_DATA = 2'h2,
      USD_TX_STOP = 2'h3
   } usd_tx_state_t;

   typedef enum logic [1:0] {
      USD_RX_IDLE = 2'h0,
      USD_RX_START = 2'h1,
      USD_RX_DATA = 2'h2,
      USD_RX_STOP = 2'h3
   } usd_rx_state_t;
endpackage

// *** logic/usd_serial.sv ***
// Serial 8N1 shifter pair for transmit and receive
`timescale 1ns/100ps
module usd_serial #(
   parameter int CLKS_PER_BIT = 1085,
   parameter int DW = 8
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_tx_start,
   input wire logic [DW-1:0] i_tx_data,
   output logic o_tx_busy,
   output logic o_tx_line,
   input wire logic i_rx_line,
   output logic o_rx_valid,
   output logic [DW-1:0] o_rx_data
);
   localparam int CW = $clog2(CLKS_PER_BIT + 1);
   localparam int BW = (DW > 1) ? $clog2(DW) : 1;
   localparam logic [CW-1:0] BIT_LAST = CW'(CLKS_PER_BIT - 1);
   localparam logic [CW-1:0] HALF = CW'(CLKS_PER_BIT / 2);
   localparam logic [BW-1:0] BIT_TOP = BW'(DW - 1);

   usd_pkg::usd_tx_state_t tx_state_reg;
   usd_pkg::usd_rx_state_t rx_state_reg;
   logic [CW-1:0] tx_cnt_reg;
   logic [CW-1:0] rx_cnt_reg;
   logic [BW-1:0] tx_bit_reg;
   logic [BW-1:0] rx_bit_reg;
   logic [DW-1:0] tx_shift_reg;
   logic [DW-1:0] rx_shift_reg;
   logic tx_line_reg;
   logic rx_valid_reg;
   logic [DW-1:0] rx_data_reg;

   assign o_tx_busy = (tx_state_reg != usd_pkg::USD_TX_IDLE);
   assign o_tx_line = tx_line_reg;
   assign o_rx_valid = rx_valid_reg;
   assign o_rx_data = rx_data_reg;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         tx_state_reg <= usd_pkg::USD_TX_IDLE;
         tx_cnt_reg <= '0;
         tx_bit_reg <= '0;
         tx_shift_reg <= '0;
         tx_line_reg <= 1'b1;
      end else begin
         case (tx_state_reg)
            usd_pkg::USD_TX_IDLE: begin
               tx_line_reg <= 1'b1;
               tx_cnt_reg <= '0;
               if (i_tx_start) begin
                  tx_shift_reg <= i_tx_data;
                  tx_line_reg <= 1'b0;
                  tx_state_reg <= usd_pkg::USD_TX_START;
               end
            end
            usd_pkg::USD_TX_START: begin
               tx_cnt_reg <= tx_cnt_reg + CW'(1);
               if (tx_cnt_reg == BIT_LAST) begin
                  tx_cnt_reg <= '0;
                  tx_bit_reg <= '0;
                  tx_line_reg <= tx_shift_reg[0];
                  tx_state_reg <= usd_pkg::USD_TX_DATA;
               end
            end
            usd_pkg::USD_TX_DATA: begin
               tx_cnt_reg <= tx_cnt_reg + CW'(1);
               if (tx_cnt_reg == BIT_LAST) begin
                  tx_cnt_reg <= '0;
                  if (tx_bit_reg == BIT_TOP) begin
                     tx_line_reg <= 1'b1;
                     tx_state_reg <= usd_pkg::USD_TX_STOP;
                  end else begin
                     tx_bit_reg <= tx_bit_reg + BW'(1);
                     tx_shift_reg <= tx_shift_reg >> 1;
                     tx_line_reg <= tx_shift_reg[1];
                  end
               end
            end
            usd_pkg::USD_TX_STOP: begin
               tx_cnt_reg <= tx_cnt_reg + CW'(1);
               if (tx_cnt_reg == BIT_LAST) begin
                  tx_state_reg <= usd_pkg::USD_TX_IDLE;
               end
            end
            default: tx_state_reg <= usd_pkg::USD_TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rx_state_reg <= usd_pkg::USD_RX_IDLE;
         rx_cnt_reg <= '0;
         rx_bit_reg <= '0;
         rx_shift_reg <= '0;
         rx_valid_reg <= 1'b0;
         rx_data_reg <= '0;
      end else begin
         rx_valid_reg <= 1'b0;
         case (rx_state_reg)
            usd_pkg::USD_RX_IDLE: begin
               rx_cnt_reg <= '0;
               if (!i_rx_line) begin
                  rx_state_reg <= usd_pkg::USD_RX_START;
               end
            end
            usd_pkg::USD_RX_START: begin
               rx_cnt_reg <= rx_cnt_reg + CW'(1);
               if (rx_cnt_reg == HALF) begin
                  rx_cnt_reg <= '0;
                  rx_bit_reg <= '0;
                  // A glitch shorter than half a bit is not a start bit
                  rx_state_reg <= i_rx_line ? usd_pkg::USD_RX_IDLE : usd_pkg::USD_RX_DATA;
               end
            end
            usd_pkg::USD_RX_DATA: begin
               rx_cnt_reg <= rx_cnt_reg + CW'(1);
               if (rx_cnt_reg == BIT_LAST) begin
                  rx_cnt_reg <= '0;
                  rx_shift_reg <= {i_rx_line, rx_shift_reg[DW-1:1]};
                  if (rx_bit_reg == BIT_TOP) begin
                     rx_state_reg <= usd_pkg::USD_RX_STOP;
                  end else begin
                     rx_bit_reg <= rx_bit_reg + BW'(1);
                  end
               end
            end
            usd_pkg::USD_RX_STOP: begin
               rx_cnt_reg <= rx_cnt_reg + CW'(1);
               if (rx_cnt_reg == BIT_LAST) begin
                  // Framing errors drop the byte silently
                  rx_valid_reg <= i_rx_line;
                  rx_data_reg <= rx_shift_reg;
                  rx_state_reg <= usd_pkg::USD_RX_IDLE;
               end
            end
            default: rx_state_reg <= usd_pkg::USD_RX_IDLE;
         endcase
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   AST_TX_STARTBIT: assert property (i_tx_start && !o_tx_busy |=> (!o_tx_line)[*2]) else $error("no start bit");
endmodule // usd_serial

// *** logic/usd_shadow_port.sv ***
// Shadow receive/transmit data port with its status, control and bus slave
`timescale 1ns/100ps
`include "usd_params.svh"

module usd_shadow_port #(
   parameter int DW = `USD_DATA_W,
   parameter int FIFO_DEPTH = `USD_FIFO_DEPTH,
   parameter int CLKS_PER_BIT = `USD_CLK_HZ / `USD_BAUD
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic [31:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_uart_rx,
   input wire logic i_ir_rx,
   output logic o_uart_tx,
   output logic o_ir_tx_n,
   output logic o_irq
);
   logic waitreq_reg;
   logic [31:0] rdata_reg;
   logic rd_had_data_reg;
   logic [31:0] rd_val;
   logic [31:0] shadow_offs;
   logic shadow_hit;
   logic fcr_hit;
   logic mode_hit;
   logic lsr_hit;
   logic int_st_hit;
   logic int_mask_hit;
   logic req;
   logic take;
   logic fire;
   logic wr_ok;
   logic rd_fire;
   logic fcr_en_reg;
   logic ir_mode_reg;
   logic [`USD_INT_W-1:0] int_mask_reg;
   logic [`USD_INT_W-1:0] int_status_reg;
   logic [`USD_INT_W-1:0] int_clr;
   logic [`USD_INT_W-1:0] int_ev;
   logic irq_reg;
   logic oe_reg;
   logic tx_empty_d_reg;
   logic [7:0] lsr_val;
   logic rx_meta_reg;
   logic rx_sync_reg;
   logic ir_meta_reg;
   logic ir_sync_reg;
   logic rx_line;
   logic rx_valid;
   logic [DW-1:0] rx_data;
   logic rx_lost;
   logic tx_start;
   logic tx_busy;
   logic tx_line;
   logic uart_tx_reg;
   logic ir_tx_n_reg;

   usd_fifo_if #(.DW(DW), .DEPTH(FIFO_DEPTH)) rx_if ();
   usd_fifo_if #(.DW(DW), .DEPTH(FIFO_DEPTH)) tx_if ();

   usd_fifo #(.DW(DW), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .f(rx_if.fifo)
   );

   usd_fifo #(.DW(DW), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .f(tx_if.fifo)
   );

   usd_serial #(.CLKS_PER_BIT(CLKS_PER_BIT), .DW(DW)) u_serial (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_tx_start(tx_start),
      .i_tx_data(tx_if.head),
      .o_tx_busy(tx_busy),
      .o_tx_line(tx_line),
      .i_rx_line(rx_line),
      .o_rx_valid(rx_valid),
      .o_rx_data(rx_data)
   );

   assign shadow_offs = i_avs_address - `USD_ADDR_SHADOW_BASE;
   assign shadow_hit = (shadow_offs < `USD_SHADOW_SPAN) && (i_avs_address[1:0] == 2'h0);
   assign fcr_hit = (i_avs_address == `USD_ADDR_FIFO_CTRL);
   assign mode_hit = (i_avs_address == `USD_ADDR_MODE_CTRL);
   assign lsr_hit = (i_avs_address == `USD_ADDR_LINE_STATUS);
   assign int_st_hit = (i_avs_address == `USD_ADDR_INT_STATUS);
   assign int_mask_hit = (i_avs_address == `USD_ADDR_INT_MASK);

   // One wait cycle per access; side effects land on the accepting edge
   assign req = i_avs_read || i_avs_write;
   assign take = req && waitreq_reg;
   assign fire = req && !waitreq_reg;
   assign wr_ok = fire && i_avs_write && i_avs_byteenable[0];
   assign rd_fire = fire && i_avs_read;

   always_comb begin
      lsr_val = 8'h00;
      lsr_val[`USD_LSR_DR] = !rx_if.empty;
      lsr_val[`USD_LSR_OE] = oe_reg;
      lsr_val[`USD_LSR_TX_HOLDING_EMPTY_FLAG] = tx_if.empty;
      lsr_val[`USD_LSR_TEMT] = tx_if.empty && !tx_busy;
   end

   always_comb begin
      rd_val = 32'h00000000;
      if (shadow_hit) begin
         if (!rx_if.empty) begin
            rd_val = 32'(rx_if.head);
         end
      end else if (fcr_hit) begin
         rd_val[`USD_FCR_EN] = fcr_en_reg;
      end else if (mode_hit) begin
         rd_val[`USD_MODE_IR] = ir_mode_reg;
      end else if (lsr_hit) begin
         rd_val = 32'(lsr_val);
      end else if (int_st_hit) begin
         rd_val = 32'(int_status_reg);
      end else if (int_mask_hit) begin
         rd_val = 32'(int_mask_reg);
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         waitreq_reg <= 1'b1;
         rdata_reg <= 32'h00000000;
         rd_had_data_reg <= 1'b0;
      end else if (take) begin
         waitreq_reg <= 1'b0;
         rdata_reg <= i_avs_read ? rd_val : 32'h00000000;
         rd_had_data_reg <= !rx_if.empty;
      end else begin
         waitreq_reg <= 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         fcr_en_reg <= 1'b0;
         ir_mode_reg <= 1'b0;
         int_mask_reg <= '0;
      end else if (wr_ok) begin
         if (fcr_hit) begin
            fcr_en_reg <= i_avs_writedata[`USD_FCR_EN];
         end
         if (mode_hit) begin
            ir_mode_reg <= i_avs_writedata[`USD_MODE_IR];
         end
         if (int_mask_hit) begin
            int_mask_reg <= i_avs_writedata[`USD_INT_W-1:0];
         end
      end
   end

   // Any FIFO control write with byte lane 0 enabled empties both queues, so a mode change never mixes depths
   assign rx_if.flush = wr_ok && fcr_hit;
   assign tx_if.flush = wr_ok && fcr_hit;
   assign rx_if.single = !fcr_en_reg;
   assign tx_if.single = !fcr_en_reg;

   assign rx_if.push = rx_valid;
   assign rx_if.push_data = rx_data;
   // A read answered with zero pops nothing, even if a byte lands meanwhile
   assign rx_if.pop = rd_fire && shadow_hit && rd_had_data_reg;
   assign rx_lost = rx_valid && rx_if.full && !rx_if.pop;

   assign tx_if.push = wr_ok && shadow_hit;
   assign tx_if.push_data = i_avs_writedata[DW-1:0];
   assign tx_start = !tx_if.empty && !tx_busy;
   assign tx_if.pop = tx_start;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rx_meta_reg <= 1'b1;
         rx_sync_reg <= 1'b1;
         ir_meta_reg <= 1'b0;
         ir_sync_reg <= 1'b0;
      end else begin
         rx_meta_reg <= i_uart_rx;
         rx_sync_reg <= rx_meta_reg;
         ir_meta_reg <= i_ir_rx;
         ir_sync_reg <= ir_meta_reg;
      end
   end

   // select receive source
   // Infrared input is taken as full-width pulses, high for a zero bit
   assign rx_line = ir_mode_reg ? !ir_sync_reg : rx_sync_reg;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         oe_reg <= 1'b0;
      end else if (rx_lost) begin
         oe_reg <= 1'b1;
      end else if (rd_fire && lsr_hit) begin
         oe_reg <= 1'b0;
      end
   end

   always_comb begin
      int_ev = '0;
      int_ev[`USD_INT_RX] = rx_valid && !rx_lost;
      int_ev[`USD_INT_OE] = rx_lost;
      int_ev[`USD_INT_TX_HOLDING_EMPTY_FLAG] = tx_if.empty && !tx_empty_d_reg;
   end

   // Only bits that the read returned are cleared; a new event still sets
   assign int_clr = (rd_fire && int_st_hit) ? rdata_reg[`USD_INT_W-1:0] : '0;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         int_status_reg <= '0;
         tx_empty_d_reg <= 1'b1;
         irq_reg <= 1'b0;
      end else begin
         int_status_reg <= (int_status_reg & ~int_clr) | int_ev;
         tx_empty_d_reg <= tx_if.empty;
         irq_reg <= |(int_status_reg & int_mask_reg);
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         uart_tx_reg <= 1'b1;
         ir_tx_n_reg <= 1'b1;
      end else begin
         uart_tx_reg <= ir_mode_reg ? 1'b1 : tx_line;
         ir_tx_n_reg <= ir_mode_reg ? tx_line : 1'b1;
      end
   end

   assign o_avs_readdata = rdata_reg;
   assign o_avs_waitrequest = waitreq_reg;
   assign o_uart_tx = uart_tx_reg;
   assign o_ir_tx_n = ir_tx_n_reg;
   assign o_irq = irq_reg;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   sequence s_new_req;
      req && o_avs_waitrequest;
   endsequence
   sequence s_answer;
      !o_avs_waitrequest ##1 o_avs_waitrequest;
   endsequence
   property p_handshake;
      s_new_req |=> s_answer;
   endproperty
   property p_rd_head;
      s_new_req ##0 (i_avs_read && shadow_hit && !rx_if.empty) |=>
         o_avs_readdata == 32'($past(rx_if.head));
   endproperty
   property p_rd_empty;
      s_new_req ##0 (i_avs_read && shadow_hit && rx_if.empty) |=> o_avs_readdata == 32'h00000000;
   endproperty
   property p_overrun;
      rx_valid && rx_if.full && !rx_if.pop |=> lsr_val[`USD_LSR_OE] && int_status_reg[`USD_INT_OE];
   endproperty
   property p_tx_holding_empty_flag_clear;
      tx_if.push && !fcr_en_reg && tx_if.empty |=> !lsr_val[`USD_LSR_TX_HOLDING_EMPTY_FLAG];
   endproperty
   property p_replace;
      tx_if.push && !fcr_en_reg && tx_if.full && !tx_start |=> tx_if.head == $past(tx_if.push_data);
   endproperty
   property p_irq;
      ##1 o_irq == $past(|(int_status_reg & int_mask_reg));
   endproperty
   property p_pin_uart;
      !ir_mode_reg |=> o_uart_tx == $past(tx_line) && o_ir_tx_n;
   endproperty

   AST_BUS_HANDSHAKE: assert property (p_handshake) else $error("no one-cycle answer");
   AST_READ_HEAD: assert property (p_rd_head) else $error("read not queue head");
   AST_READ_EMPTY: assert property (p_rd_empty) else $error("read without data ready");
   AST_UPPER_ZERO: assert property (s_new_req ##0 (i_avs_read && shadow_hit) |=>
      o_avs_readdata[31:8] == 24'h000000) else $error("upper bits set");
   AST_OVERRUN: assert property (p_overrun) else $error("overrun not flagged");
   AST_TX_HOLDING_EMPTY_FLAG_CLEAR: assert property (p_tx_holding_empty_flag_clear) else $error("holding empty not cleared");
   AST_REPLACE: assert property (p_replace) else $error("pending byte not replaced");
   AST_IRQ: assert property (p_irq) else $error("interrupt not status and mask");
   AST_PIN_UART: assert property (p_pin_uart) else $error("serial output wrong");
endmodule // usd_shadow_port
